// [rtl/asmon_pkg.sv]
// adc signal monitor: register map, field positions and reset values
// assumes an 8-bit register port with 16-bit addresses, one clock domain
package asmon_pkg;

	// register offsets
	localparam logic [15:0] ASMON_ADDR_SYNC_CTRL    = 16'h026f; // sync control
	localparam logic [15:0] ASMON_ADDR_MON_CTRL     = 16'h0270; // detector enable
	localparam logic [15:0] ASMON_ADDR_PERIOD_LOW   = 16'h0271; // period bits 7:0
	localparam logic [15:0] ASMON_ADDR_PERIOD_MID   = 16'h0272; // period bits 15:8
	localparam logic [15:0] ASMON_ADDR_PERIOD_HIGH  = 16'h0273; // period bits 23:16
	localparam logic [15:0] ASMON_ADDR_STATUS_CTRL  = 16'h0274; // update and select
	localparam logic [15:0] ASMON_ADDR_RESULT_LOW   = 16'h0275; // result bits 7:0
	localparam logic [15:0] ASMON_ADDR_RESULT_MID   = 16'h0276; // result bits 15:8
	localparam logic [15:0] ASMON_ADDR_RESULT_HIGH  = 16'h0277; // result bits 19:16
	localparam logic [15:0] ASMON_ADDR_FRAME_COUNT  = 16'h0278; // expired periods
	localparam logic [15:0] ASMON_ADDR_LINK_ENABLE  = 16'h0279; // link framer enable
	localparam logic [15:0] ASMON_ADDR_LINK_SELECT  = 16'h027a; // link input select

	// field positions
	localparam int          ASMON_SYNC_EN_BIT    = 0; // sync enable
	localparam int          ASMON_NEXT_SYNC_BIT  = 1; // next-sync mode
	localparam int          ASMON_PEAK_EN_BIT    = 1; // peak detector enable
	localparam int          ASMON_UPDATE_BIT     = 4; // result update strobe
	localparam int          ASMON_LINK_PEAK_BIT  = 1; // peak into serial frame

	// field encodings
	localparam logic [2:0]  ASMON_SEL_PEAK       = 3'h1; // peak on readback
	localparam logic [1:0]  ASMON_LINK_ON        = 2'h3; // framer enabled

	// widths
	localparam int          ASMON_PERIOD_W       = 24; // period counter width
	localparam int          ASMON_RESULT_W       = 20; // result width
	localparam int          ASMON_FRAME_W        = 8;  // frame counter width

	// reset values
	localparam logic [23:0] ASMON_PERIOD_RESET   = 24'h000080; // default period
	localparam logic [2:0]  ASMON_SEL_RESET      = 3'h1;       // peak selected
	localparam logic [1:0]  ASMON_LINK_EN_RESET  = 2'h0;       // framer off
	localparam logic        ASMON_LINK_SEL_RESET = 1'b1;       // peak inserted

endpackage

// [rtl/asmon_peak_track.sv]
// adc signal monitor: running peak magnitude within one period
// assumes samples are two's complement and on the same clock as the tracker
`timescale 1ns/10ps
module asmon_peak_track
#(
	parameter int SAMPLE_W = 14,
	parameter int RESULT_W = 20
)
(
	input  wire logic                clk,
	input  wire logic                rst_b,
	input  wire logic [SAMPLE_W-1:0] sample,
	input  wire logic                enable,
	input  wire logic                restart,
	output logic      [RESULT_W-1:0] track_max,
	output logic      [RESULT_W-1:0] peak_reg
);

	logic [SAMPLE_W-1:0] mag;  // magnitude, unsigned so full negative fits
	logic [RESULT_W-1:0] mag_ext; // magnitude widened to result

	// absolute value of the current sample
	always_comb
	begin
		mag = sample[SAMPLE_W-1] ? SAMPLE_W'(-sample) : sample;
		mag_ext = RESULT_W'(mag);
		// max including this cycle, so the closing sample is not lost
		if (!enable)
			track_max = '0;
		else if (mag_ext > peak_reg)
			track_max = mag_ext;
		else
			track_max = peak_reg;
	end

	// hold the running peak, cleared at each period start
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			peak_reg <= '0;
		else if (restart || !enable)
			peak_reg <= '0; // [R12]
		else
			peak_reg <= track_max; // [R12]
	end

	AST_PEAK_MONOTONIC: assert property (@(posedge clk) disable iff (!rst_b) // [R12]
		(enable && !restart) |=> (peak_reg >= $past(peak_reg)))
		else $error("peak dropped inside a period");

endmodule

// [rtl/asmon_top.sv]
// adc signal monitor: period counter, peak result, status readback, link frame
// assumes an 8-bit register port on clk and a sysref pin from outside the domain
`timescale 1ns/10ps
// Operation
// R1: 24-bit period in cycles, default 0x80
// R2: software programs only even periods
// R3: update bit latches result, self-clears
// R4: select 001 routes peak to readback
// R5: 20-bit result over three bytes, nibble zero
// R6: 8-bit frame counter counts period expiries
// R7: link insertion enable field, 11 on
// R8: select bit 1 inserts peak data
// R9: control bit enables peak detector
// R10: next-sync uses first sysref edge only
// R11: captured edge clears sync enable bit
// R12: peak tracked per period, restarted each expiry
module asmon_top
	import asmon_pkg::*;
#(
	parameter int SAMPLE_W = 14
)
(
	input  wire logic                      clk,
	input  wire logic                      rst_b,
	input  wire logic [SAMPLE_W-1:0]       sample,
	input  wire logic                      sysref_pin,
	input  wire logic [15:0]               reg_addr,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	input  wire logic [7:0]                reg_wdata,
	output logic      [7:0]                reg_rdata_reg,
	output logic                           status_serial_port_valid_reg,
	output logic      [ASMON_RESULT_W-1:0] status_serial_port_data_reg
);

	// configuration state
	logic [23:0]               period_reg;        // measurement length
	logic                      sync_en_reg;       // sync enable
	logic                      next_sync_reg;     // next-sync mode
	logic                      peak_en_reg;       // peak detector enable
	logic [2:0]                sel_reg;           // readback selection
	logic                      update_reg;        // update strobe, one cycle
	logic [1:0]                link_en_reg;       // framer enable field
	logic                      link_peak_reg;     // peak into frame
	// measurement state
	logic [23:0]               period_cnt_reg;    // counts down to expiry
	logic [23:0]               period_cnt_next;   // next count
	logic [ASMON_RESULT_W-1:0] result_reg;        // last delivered statistic
	logic [ASMON_FRAME_W-1:0]  frame_cnt_reg;     // expiries seen
	logic [ASMON_RESULT_W-1:0] status_result_reg; // software-visible result
	logic [ASMON_FRAME_W-1:0]  status_frame_reg;  // software-visible count
	// sysref synchroniser and edge
	logic                      sysref_s1_reg;     // first stage, read by s2 only
	logic                      sysref_s2_reg;     // second stage
	logic                      sysref_s3_reg;     // third stage
	logic                      sysref_lvl_reg;    // agreed level
	logic                      sysref_edge;       // agreed rising edge
	logic                      sync_hit;          // edge that realigns
	// datapath
	logic                      expire;            // period counter at zero
	logic                      restart;           // period boundary
	logic [23:0]               reload;            // count loaded at boundary
	logic [ASMON_RESULT_W-1:0] track_max;         // running peak incl. now
	logic [ASMON_RESULT_W-1:0] peak_reg;          // tracker state
	logic                      wr_sync;           // write to sync control
	logic                      wr_status;         // write to status control

	assign wr_sync   = reg_wr && (reg_addr == ASMON_ADDR_SYNC_CTRL);
	assign wr_status = reg_wr && (reg_addr == ASMON_ADDR_STATUS_CTRL);

	// sysref passes three flops; a change counts once stages two and three agree
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sysref_s1_reg  <= 1'b0;
			sysref_s2_reg  <= 1'b0;
			sysref_s3_reg  <= 1'b0;
			sysref_lvl_reg <= 1'b0;
		end
		else
		begin
			sysref_s1_reg <= sysref_pin;
			sysref_s2_reg <= sysref_s1_reg;
			sysref_s3_reg <= sysref_s2_reg;
			// hold the last agreed level while the stages disagree
			if (sysref_s2_reg == sysref_s3_reg)
				sysref_lvl_reg <= sysref_s3_reg;
		end
	end

	assign sysref_edge = (sysref_s2_reg == sysref_s3_reg) && sysref_s3_reg && !sysref_lvl_reg;
	// enable gates every edge; next-sync clears enable after the first
	assign sync_hit    = sysref_edge && sync_en_reg; // [R10]

	// sync control: software bits, hardware clear in next-sync mode
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sync_en_reg   <= 1'b0;
			next_sync_reg <= 1'b0;
		end
		else if (wr_sync)
		begin
			// a write in the capture cycle wins, so a re-arm is not lost
			sync_en_reg   <= reg_wdata[ASMON_SYNC_EN_BIT];
			next_sync_reg <= reg_wdata[ASMON_NEXT_SYNC_BIT];
		end
		else if (sync_hit && next_sync_reg)
			sync_en_reg <= 1'b0; // [R11] later edges ignored [R10]
	end

	// configuration registers written by software
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			period_reg    <= ASMON_PERIOD_RESET;
			peak_en_reg   <= 1'b0;
			sel_reg       <= ASMON_SEL_RESET;
			link_en_reg   <= ASMON_LINK_EN_RESET;
			link_peak_reg <= ASMON_LINK_SEL_RESET;
		end
		else if (reg_wr)
		begin
			unique case (reg_addr)
				ASMON_ADDR_PERIOD_LOW:  period_reg[7:0]   <= reg_wdata; // [R1]
				ASMON_ADDR_PERIOD_MID:  period_reg[15:8]  <= reg_wdata; // [R1]
				ASMON_ADDR_PERIOD_HIGH: period_reg[23:16] <= reg_wdata; // [R1]
				ASMON_ADDR_MON_CTRL:    peak_en_reg   <= reg_wdata[ASMON_PEAK_EN_BIT]; // [R9]
				ASMON_ADDR_STATUS_CTRL: sel_reg       <= reg_wdata[2:0]; // [R4]
				ASMON_ADDR_LINK_ENABLE: link_en_reg   <= reg_wdata[1:0]; // [R7]
				ASMON_ADDR_LINK_SELECT: link_peak_reg <= reg_wdata[ASMON_LINK_PEAK_BIT]; // [R8]
				// sync control is written above; other addresses hold no writable bits
				default: ;
			endcase
		end
	end

	// update strobe: set by the write, gone one cycle later
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			update_reg <= 1'b0;
		else
			update_reg <= wr_status && reg_wdata[ASMON_UPDATE_BIT]; // [R3]
	end

	// period counter: counts period-1 down to 0, so one expiry per period cycles
	// odd periods are not guarded here; software keeps them even [R2]
	assign expire  = (period_cnt_reg == 24'h000000);
	assign restart = expire || sync_hit;
	assign reload  = (period_reg == 24'h000000) ? 24'h000000 : period_reg - 24'h000001;

	always_comb
	begin
		if (restart)
			period_cnt_next = reload; // [R1] realign on sysref [R10]
		else
			period_cnt_next = period_cnt_reg - 24'h000001;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			period_cnt_reg <= ASMON_PERIOD_RESET - 24'h000001;
		else
			period_cnt_reg <= period_cnt_next;
	end

	// peak tracker, restarted at each boundary
	asmon_peak_track
	#(
		.SAMPLE_W (SAMPLE_W),
		.RESULT_W (ASMON_RESULT_W)
	)
	u_peak
	(
		.clk       (clk),
		.rst_b     (rst_b),
		.sample    (sample),
		.enable    (peak_en_reg), // [R9]
		.restart   (restart),
		.track_max (track_max),
		.peak_reg  (peak_reg)
	);

	// result delivery and frame count at each expiry
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			result_reg    <= '0;
			frame_cnt_reg <= '0;
		end
		else if (expire)
		begin
			result_reg    <= track_max;                       // [R12]
			frame_cnt_reg <= frame_cnt_reg + 8'h01;           // [R6] wraps at 8 bits
		end
	end

	// status snapshot on the update strobe; selection picks the statistic
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			status_result_reg <= '0;
			status_frame_reg  <= '0;
		end
		else if (update_reg)
		begin
			// only the peak detector exists; other codes read as zero
			status_result_reg <= (sel_reg == ASMON_SEL_PEAK) ? result_reg : '0; // [R3] [R4]
			status_frame_reg  <= frame_cnt_reg; // [R3] [R6]
		end
	end

	// serial status frame word, one pulse per expiry while enabled
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			status_serial_port_valid_reg <= 1'b0;
			status_serial_port_data_reg  <= '0;
		end
		else
		begin
			status_serial_port_valid_reg <= expire && (link_en_reg == ASMON_LINK_ON); // [R7]
			if (expire)
				// omitted statistic is sent as zero so the frame keeps its shape
				status_serial_port_data_reg <= link_peak_reg ? track_max : '0; // [R8]
		end
	end

	// registered read data, valid the cycle after reg_rd
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			reg_rdata_reg <= 8'h00;
		else if (reg_rd)
		begin
			unique case (reg_addr)
				ASMON_ADDR_SYNC_CTRL:   reg_rdata_reg <= {6'h00, next_sync_reg, sync_en_reg};
				ASMON_ADDR_MON_CTRL:    reg_rdata_reg <= {6'h00, peak_en_reg, 1'b0};
				ASMON_ADDR_PERIOD_LOW:  reg_rdata_reg <= period_reg[7:0];
				ASMON_ADDR_PERIOD_MID:  reg_rdata_reg <= period_reg[15:8];
				ASMON_ADDR_PERIOD_HIGH: reg_rdata_reg <= period_reg[23:16];
				ASMON_ADDR_STATUS_CTRL: reg_rdata_reg <= {3'h0, update_reg, 1'b0, sel_reg};
				ASMON_ADDR_RESULT_LOW:  reg_rdata_reg <= status_result_reg[7:0];   // [R5]
				ASMON_ADDR_RESULT_MID:  reg_rdata_reg <= status_result_reg[15:8];  // [R5]
				ASMON_ADDR_RESULT_HIGH: reg_rdata_reg <= {4'h0, status_result_reg[19:16]}; // [R5]
				ASMON_ADDR_FRAME_COUNT: reg_rdata_reg <= status_frame_reg; // [R6]
				ASMON_ADDR_LINK_ENABLE: reg_rdata_reg <= {6'h00, link_en_reg};
				ASMON_ADDR_LINK_SELECT: reg_rdata_reg <= {6'h00, link_peak_reg, 1'b0};
				// unmapped addresses read zero
				default:                reg_rdata_reg <= 8'h00;
			endcase
		end
	end

	AST_PERIOD_RELOAD: assert property (@(posedge clk) disable iff (!rst_b) // [R1]
		(expire && !sync_hit) |=> (period_cnt_reg == $past(reload)))
		else $error("period counter not reloaded at expiry");

	AST_PERIOD_COUNTDOWN: assert property (@(posedge clk) disable iff (!rst_b) // [R1]
		(!restart) |=> (period_cnt_reg == $past(period_cnt_reg) - 24'h000001))
		else $error("period counter skipped a cycle");

	AST_UPDATE_COPY: assert property (@(posedge clk) disable iff (!rst_b) // [R3]
		(wr_status && reg_wdata[ASMON_UPDATE_BIT]) ##1 (sel_reg == ASMON_SEL_PEAK)
		|=> (status_result_reg == $past(result_reg)) && (status_frame_reg == $past(frame_cnt_reg)))
		else $error("update did not copy result and count");

	AST_UPDATE_SELF_CLEAR: assert property (@(posedge clk) disable iff (!rst_b) // [R3]
		(update_reg && !(wr_status && reg_wdata[ASMON_UPDATE_BIT])) |=> !update_reg)
		else $error("update bit did not clear");

	AST_SELECT_OTHER_ZERO: assert property (@(posedge clk) disable iff (!rst_b) // [R4]
		(update_reg && (sel_reg != ASMON_SEL_PEAK)) |=> (status_result_reg == '0))
		else $error("unselected statistic reached readback");

	AST_RESULT_HIGH_NIBBLE: assert property (@(posedge clk) disable iff (!rst_b) // [R5]
		(reg_rd && (reg_addr == ASMON_ADDR_RESULT_HIGH)) |=> (reg_rdata_reg[7:4] == 4'h0))
		else $error("result upper nibble not zero");

	AST_FRAME_INCREMENT: assert property (@(posedge clk) disable iff (!rst_b) // [R6]
		expire |=> (frame_cnt_reg == $past(frame_cnt_reg) + 8'h01))
		else $error("frame counter did not step at expiry");

	AST_LINK_GATED: assert property (@(posedge clk) disable iff (!rst_b) // [R7]
		status_serial_port_valid_reg |-> ($past(link_en_reg) == ASMON_LINK_ON) && $past(expire))
		else $error("frame word sent while framer disabled");

	AST_LINK_PEAK_OMIT: assert property (@(posedge clk) disable iff (!rst_b) // [R8]
		(expire && !link_peak_reg) |=> (status_serial_port_data_reg == '0))
		else $error("peak inserted while deselected");

	AST_PEAK_OFF: assert property (@(posedge clk) disable iff (!rst_b) // [R9]
		(!peak_en_reg) |=> (peak_reg == '0))
		else $error("peak tracked while disabled");

	AST_NEXT_SYNC_CLEAR: assert property (@(posedge clk) disable iff (!rst_b) // [R11]
		(sync_hit && next_sync_reg && !wr_sync) |=> !sync_en_reg ##1 !sync_hit)
		else $error("sync enable not cleared after captured edge");

	AST_SYNC_REALIGN: assert property (@(posedge clk) disable iff (!rst_b) // [R10]
		sync_hit |=> (period_cnt_reg == $past(reload)))
		else $error("sysref edge did not realign period");

endmodule

// [verification/asmon_link_sink.sv]
// link sink: far end of the status serial port, keeps every frame word
// assumes words arrive as one-cycle valid pulses on the monitor clock
`timescale 1ns/10ps
module asmon_link_sink
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        valid,
	input  wire logic [19:0] data
);
	logic [19:0] got [$]; // words in arrival order

	// no back-pressure on this link, so the sink only records
	always @(posedge clk)
	begin
		if (rst_b && valid)
			got.push_back(data);
	end
endmodule

// [verification/adc_signal_monitor_bench.sv]
// bench: register map checks and link words against a cycle model
// assumes asmon_top with 20-bit samples so result bits 19:16 are reachable
`timescale 1ns/10ps
module adc_signal_monitor_bench
	import asmon_pkg::*;
();
	localparam int SW = 20; // wide samples reach the top nibble
	logic          clk, rst_b, sysref_pin, reg_wr, reg_rd, link_valid;
	logic [SW-1:0] sample;
	logic [15:0]   reg_addr;
	logic [7:0]    reg_wdata, reg_rdata_reg, m_frames, snap_frm;
	logic [19:0]   link_data, m_max, m_last, snap_res;
	logic [23:0]   m_cnt, m_period;
	logic [2:0]    m_sel;
	logic [1:0]    m_link_en;
	logic          m_peak_en, m_link_sel, m_upd;
	logic [3:0]    m_sh; // last four sysref samples, newest in bit 0
	logic          m_sync_en, m_next, m_hit;
	logic [19:0]   exp_q [$]; // words the link should carry
	int            m_exp, miscompares, cmp_count;

	asmon_top #(.SAMPLE_W(SW)) u_dut
	(
		.clk                          (clk),
		.rst_b                        (rst_b),
		.sample                       (sample),
		.sysref_pin                   (sysref_pin),
		.reg_addr                     (reg_addr),
		.reg_wr                       (reg_wr),
		.reg_rd                       (reg_rd),
		.reg_wdata                    (reg_wdata),
		.reg_rdata_reg                (reg_rdata_reg),
		.status_serial_port_valid_reg (link_valid),
		.status_serial_port_data_reg  (link_data)
	);
	asmon_link_sink u_sink (.clk(clk), .rst_b(rst_b), .valid(link_valid), .data(link_data));

	// 100 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	function automatic logic [19:0] f_mag(input logic [19:0] s);
		return s[19] ? (20'h00000 - s) : s;
	endfunction

	function automatic logic [7:0] f_reset(input logic [15:0] a);
		case (a)
			ASMON_ADDR_PERIOD_LOW:  return ASMON_PERIOD_RESET[7:0];
			ASMON_ADDR_STATUS_CTRL: return {5'h00, ASMON_SEL_RESET};
			ASMON_ADDR_LINK_SELECT: return {6'h00, ASMON_LINK_SEL_RESET, 1'b0};
			default:                return 8'h00;
		endcase
	endfunction

	// cycle model: expiry first, then the write of the same edge lands
	always @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			{m_cnt, m_period, m_max, m_last} = {24'h00007f, ASMON_PERIOD_RESET, 40'h0};
			{m_sel, m_link_en, m_link_sel} = {ASMON_SEL_RESET, 2'h0, 1'b1};
			{m_peak_en, m_upd, m_frames, m_exp} = '0;
			{m_sh, m_sync_en, m_next, m_hit} = '0;
		end
		else
		begin
			if (m_upd) // snapshot one edge after the update write
				{snap_res, snap_frm} = {(m_sel == ASMON_SEL_PEAK) ? m_last : 20'h0, m_frames};
			m_upd = 1'b0;
			if (!m_peak_en) // a disabled detector holds zero
				m_max = 20'h00000;
			else if (f_mag(sample) > m_max)
				m_max = f_mag(sample);
			if (m_cnt == 24'h000000)
			begin
				m_last = m_max;
				m_frames = m_frames + 8'h01;
				m_exp++;
				if (m_link_en == ASMON_LINK_ON)
					exp_q.push_back(m_link_sel ? m_max : 20'h00000);
				m_max = 20'h00000;
				m_cnt = m_period - 24'h000001;
			end
			else
				m_cnt = m_cnt - 24'h000001;
			// a rise seen on three samples realigns; not an expiry
			m_hit = m_sync_en && (m_sh == 4'b0111);
			if (m_hit)
			begin
				m_cnt = m_period - 24'h000001;
				m_max = 20'h00000;
				if (m_next)
					m_sync_en = 1'b0;
			end
			m_sh = {m_sh[2:0], sysref_pin};
			if (reg_wr)
				case (reg_addr)
					ASMON_ADDR_SYNC_CTRL:   {m_next, m_sync_en} = reg_wdata[1:0];
					ASMON_ADDR_MON_CTRL:    m_peak_en = reg_wdata[1];
					ASMON_ADDR_PERIOD_LOW:  m_period[7:0] = reg_wdata;
					ASMON_ADDR_PERIOD_MID:  m_period[15:8] = reg_wdata;
					ASMON_ADDR_PERIOD_HIGH: m_period[23:16] = reg_wdata;
					ASMON_ADDR_STATUS_CTRL: {m_upd, m_sel} = {reg_wdata[4], reg_wdata[2:0]};
					ASMON_ADDR_LINK_ENABLE: m_link_en = reg_wdata[1:0];
					ASMON_ADDR_LINK_SELECT: m_link_sel = reg_wdata[1];
					default:                ;
				endcase
		end
	end

	// samples: mid-range noise with rare full-scale spikes
	always @(posedge clk)
	begin
		#1;
		case ($urandom % 128)
			0:       sample = 20'h80000; // most negative, magnitude 2^19
			1:       sample = 20'h7ffff;
			default: sample = 20'($urandom % 32'h40000) - 20'h20000;
		endcase
	end

	task automatic check(input logic [19:0] seen, input logic [19:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		{reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
		@(posedge clk);
		#1;
		reg_wr = 1'b0;
	endtask

	task automatic read_check(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk);
		#1;
		{reg_addr, reg_rd} = {a, 1'b1};
		@(posedge clk);
		#1;
		reg_rd = 1'b0;
		check({12'h0, reg_rdata_reg}, {12'h0, e});
	endtask

	// update strobe, then all four status bytes against the model snapshot
	task automatic snap_check();
		reg_write(ASMON_ADDR_STATUS_CTRL, 8'h11);
		@(posedge clk);
		#1;
		read_check(ASMON_ADDR_RESULT_LOW, snap_res[7:0]);
		read_check(ASMON_ADDR_RESULT_MID, snap_res[15:8]);
		read_check(ASMON_ADDR_RESULT_HIGH, {4'h0, snap_res[19:16]});
		read_check(ASMON_ADDR_FRAME_COUNT, snap_frm);
	endtask

	task automatic wait_expiries(input int n);
		int start;
		start = m_exp;
		for (int g = 0; g < 5000 && m_exp < start + n; g++)
			@(posedge clk);
		if (m_exp < start + n)
			miscompares++; // no expiry in time counts against the run
	endtask

	// stop the link, then every word against the model queue
	task automatic link_check();
		reg_write(ASMON_ADDR_LINK_ENABLE, 8'h00);
		repeat (3) @(posedge clk);
		check(20'(u_sink.got.size()), 20'(exp_q.size()));
		foreach (exp_q[i])
			if (i < u_sink.got.size())
				check(u_sink.got[i], exp_q[i]);
	endtask

	task automatic pulse_sysref();
		@(posedge clk);
		#1;
		sysref_pin = 1'b1;
		repeat (6) @(posedge clk);
		#1;
		sysref_pin = 1'b0;
		repeat (6) @(posedge clk);
	endtask

	task automatic give_verdict();
		if (miscompares == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// watchdog well beyond the expected run of some 5000 cycles
	initial
	begin
		repeat (40000) @(posedge clk);
		miscompares++;
		give_verdict();
	end

	initial
	begin
		logic [7:0] p;
		{rst_b, sysref_pin, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		{sample, miscompares, cmp_count} = '0;
		void'($urandom(32'hd2ce9063));
		repeat (16) @(posedge clk);
		#1;
		rst_b = 1'b1;
		// reset table, 0x027b is unmapped and reads zero
		for (int a = 16'h026f; a <= 16'h027b; a++)
			read_check(16'(a), f_reset(16'(a)));
		p = 8'h14 + 8'(2 * ($urandom % 21)); // even periods only
		reg_write(ASMON_ADDR_MON_CTRL, 8'h02);
		reg_write(ASMON_ADDR_PERIOD_LOW, p);
		reg_write(ASMON_ADDR_PERIOD_MID, 8'h01);
		reg_write(ASMON_ADDR_PERIOD_HIGH, 8'h00);
		read_check(ASMON_ADDR_PERIOD_LOW, p);
		read_check(ASMON_ADDR_PERIOD_MID, 8'h01);
		read_check(ASMON_ADDR_PERIOD_HIGH, 8'h00);
		wait_expiries(2);
		// every enable code, then peak omitted, then peak again
		for (int i = 0; i < 6; i++)
		begin
			reg_write(ASMON_ADDR_LINK_SELECT, (i == 4) ? 8'h00 : 8'h02);
			reg_write(ASMON_ADDR_LINK_ENABLE, (i > 3) ? 8'h03 : 8'(i));
			wait_expiries(2);
		end
		link_check();
		// non-peak selection snapshots zero; result bytes are read-only
		reg_write(ASMON_ADDR_STATUS_CTRL, 8'hff);
		read_check(ASMON_ADDR_STATUS_CTRL, 8'h07);
		read_check(ASMON_ADDR_RESULT_LOW, 8'h00);
		reg_write(ASMON_ADDR_RESULT_LOW, 8'ha5);
		snap_check();
		// detector off across two expiries gives a zero result
		reg_write(ASMON_ADDR_MON_CTRL, 8'h00);
		wait_expiries(2);
		snap_check();
		// next-sync clears the enable, continuous mode keeps it;
		// link words with live peaks show where each period was realigned
		reg_write(ASMON_ADDR_MON_CTRL, 8'h02);
		reg_write(ASMON_ADDR_LINK_ENABLE, 8'h03);
		reg_write(ASMON_ADDR_SYNC_CTRL, 8'h03);
		pulse_sysref();
		read_check(ASMON_ADDR_SYNC_CTRL, 8'h02);
		pulse_sysref(); // ignored once the enable has cleared
		reg_write(ASMON_ADDR_SYNC_CTRL, 8'h01);
		pulse_sysref();
		read_check(ASMON_ADDR_SYNC_CTRL, 8'h01);
		pulse_sysref();
		wait_expiries(2);
		link_check();
		give_verdict();
	end
endmodule
